//--- src/lsc_top.v
`timescale 1ns/1ps
`include "lsc_defines.vh"

// Functional notes
// - seven low-speed pins, two form serial bus
// - answer serial bus only while selected low
// - host reads and writes memory map serially
// - long reset pulse restores all defaults
// - completion raises interrupt, clears data-not-ready
// - power-up posts completion interrupt unprompted
// - low power input limits power consumption
// - module pulls presence line to ground
// - transmitter off by pin or serial command
// - loss alarm when any lane below threshold
// - per-lane received power readable over bus
module lsc_top #(
   parameter [6:0] DEV_ADDR = `LSC_DEV_ADDR,
   parameter [7:0] ID_VALUE = `LSC_ID_VALUE,
   parameter       RST_MIN_NS = `LSC_RST_MIN_NS,
   parameter       INIT_NS    = `LSC_INIT_NS
) (
   input  wire        i_ref_clk,
   input  wire        i_rst_n,
   input  wire        i_module_select_n,
   input  wire        i_module_reset_n,
   input  wire        i_low_power_select,
   input  wire        i_scl,
   input  wire        i_sda,
   output reg         o_sda_out,
   output reg         o_sda_oe,
   output reg         o_module_present_n_out,
   output reg         o_module_present_n_oe,
   output reg         o_interrupt_n,
   input  wire        i_transmit_disable,
   output reg  [3:0]  o_tx_off,
   input  wire [3:0]  i_lane_below_thr,
   output reg         o_receive_loss_alarm,
   input  wire [31:0] i_rx_power,
   output reg         o_low_power_active
);
   // arbitrary identification value in ID_VALUE
   localparam integer RST_MIN_CYC =
      (RST_MIN_NS + `LSC_CLK_PERIOD_NS - 1) / `LSC_CLK_PERIOD_NS;
   localparam integer INIT_CYC_R = INIT_NS / `LSC_CLK_PERIOD_NS;
   localparam integer INIT_CYC = (INIT_CYC_R < 1) ? 1 : INIT_CYC_R;

   localparam [6:0] S_IDLE  = 7'h01;
   localparam [6:0] S_ADDR  = 7'h02;
   localparam [6:0] S_ACK_A = 7'h04;
   localparam [6:0] S_WR    = 7'h08;
   localparam [6:0] S_ACK_W = 7'h10;
   localparam [6:0] S_RD    = 7'h20;
   localparam [6:0] S_ACK_R = 7'h40;

   // pins into clock domain, lanes in top four bits
   wire [9:0] sync_w;
   lsc_sync #(
      .W       (10),
      .RST_VAL (`LSC_SYNC_RST)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_async   ({i_lane_below_thr, i_transmit_disable, i_low_power_select,
                   i_module_reset_n, i_module_select_n, i_sda, i_scl}),
      .o_sync    (sync_w)
   );

   wire       scl_s  = sync_w[`LSC_S_SCL];
   wire       sda_s  = sync_w[`LSC_S_SDA];
   wire       sel_s  = ~sync_w[`LSC_S_SEL];
   wire       mrst_s = ~sync_w[`LSC_S_RST];
   wire       lpm_s  = sync_w[`LSC_S_LPM];
   wire       txd_s  = sync_w[`LSC_S_TXD];
   wire [3:0] los_s  = sync_w[`LSC_S_LOS+3:`LSC_S_LOS];

   // module reset pin pulse filter
   reg [31:0] rlow_cnt_q;
   reg        soft_rst_q;
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rlow_cnt_q <= 32'h0;
         soft_rst_q <= 1'b0;
      end else if (mrst_s) begin
         if (rlow_cnt_q < RST_MIN_CYC[31:0])
            rlow_cnt_q <= rlow_cnt_q + 32'h1;
         else
            soft_rst_q <= 1'b1;
      end else begin
         rlow_cnt_q <= 32'h0;
         soft_rst_q <= 1'b0;
      end
   end

   wire rst_all = !i_rst_n || soft_rst_q;

   // reset completion sequencing
   reg [31:0] init_cnt_q;
   reg        dnr_q;
   reg        done_pulse_q;
   always @(posedge i_ref_clk) begin
      if (rst_all) begin
         init_cnt_q   <= 32'h0;
         dnr_q        <= 1'b1;
         done_pulse_q <= 1'b0;
      end else begin
         done_pulse_q <= 1'b0;
         if (dnr_q) begin
            if (init_cnt_q < INIT_CYC[31:0] - 32'h1) begin
               init_cnt_q <= init_cnt_q + 32'h1;
            end else begin
               dnr_q        <= 1'b0;
               done_pulse_q <= 1'b1;
            end
         end
      end
   end

   // serial bus edge detection
   reg scl_p_q;
   reg sda_p_q;
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // memory map state
   reg [6:0] st_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] sh_q;
   reg [7:0] ptr_q;
   reg       rw_q;
   reg       first_q;
   reg [3:0] transmit_disable_q;
   reg [3:0] los_flag_q;
   reg [3:0] los_p_q;
   reg       int_flag_q;
   reg [7:0] rd_data;

   always @* begin
      case (ptr_q)
         `LSC_A_ID:        rd_data = ID_VALUE;
         `LSC_A_STATUS:    rd_data = {4'h0, txd_s, lpm_s, int_flag_q, dnr_q};
         `LSC_A_LOS_FLAGS: rd_data = {4'h0, los_flag_q};
         `LSC_A_TRANSMIT_DISABLE:    rd_data = {4'h0, transmit_disable_q};
         `LSC_A_RXPWR0:    rd_data = i_rx_power[7:0];
         `LSC_A_RXPWR1:    rd_data = i_rx_power[15:8];
         `LSC_A_RXPWR2:    rd_data = i_rx_power[23:16];
         `LSC_A_RXPWR3:    rd_data = i_rx_power[31:24];
         default:          rd_data = 8'h00;
      endcase
   end

   wire load_rd  = (scl_fall && st_q == S_ACK_A && rw_q) ||
                   (scl_fall && st_q == S_ACK_R && !sh_q[0]);
   wire rd_stat  = load_rd && ptr_q == `LSC_A_STATUS;
   wire rd_los   = load_rd && ptr_q == `LSC_A_LOS_FLAGS;
   wire wr_byte  = scl_fall && st_q == S_WR && bit_cnt_q == 4'h8;
   wire new_los  = |(los_s & ~los_p_q);

   // sticky flags, set beats read-clear
   always @(posedge i_ref_clk) begin
      if (rst_all) begin
         los_flag_q <= 4'h0;
         los_p_q    <= 4'h0;
         int_flag_q <= 1'b0;
      end else begin
         los_p_q    <= los_s;
         los_flag_q <= (rd_los ? 4'h0 : los_flag_q) | (los_s & ~los_p_q);
         if (done_pulse_q || new_los)
            int_flag_q <= 1'b1;
         else if (rd_stat)
            int_flag_q <= 1'b0;
      end
   end

   // two-wire slave
   always @(posedge i_ref_clk) begin
      if (rst_all) begin
         st_q      <= S_IDLE;
         bit_cnt_q <= 4'h0;
         sh_q      <= 8'h00;
         ptr_q     <= 8'h00;
         rw_q      <= 1'b0;
         first_q   <= 1'b0;
         transmit_disable_q  <= `LSC_TRANSMIT_DISABLE_RST;
         o_sda_oe  <= 1'b0;
      end else if (start_c) begin
         o_sda_oe  <= 1'b0;
         bit_cnt_q <= 4'h0;
         first_q   <= 1'b1;
         st_q      <= (sel_s && !dnr_q) ? S_ADDR : S_IDLE;
      end else if (stop_c || (!sel_s && st_q != S_IDLE)) begin
         o_sda_oe <= 1'b0;
         st_q     <= S_IDLE;
      end else begin
         case (st_q)
            S_IDLE: begin
               o_sda_oe <= 1'b0;
            end
            S_ADDR, S_WR: begin
               if (scl_rise && bit_cnt_q < 4'h8) begin
                  sh_q      <= {sh_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == 4'h8) begin
                  bit_cnt_q <= 4'h0;
                  if (st_q == S_ADDR) begin
                     if (sh_q[7:1] == DEV_ADDR) begin
                        rw_q     <= sh_q[0];
                        o_sda_oe <= 1'b1;
                        st_q     <= S_ACK_A;
                     end else begin
                        st_q <= S_IDLE;
                     end
                  end else begin
                     if (first_q) begin
                        ptr_q   <= sh_q;
                        first_q <= 1'b0;
                     end else begin
                        if (wr_byte && ptr_q == `LSC_A_TRANSMIT_DISABLE)
                           transmit_disable_q <= sh_q[3:0];
                        ptr_q <= ptr_q + 8'h1;
                     end
                     o_sda_oe <= 1'b1;
                     st_q     <= S_ACK_W;
                  end
               end
            end
            S_ACK_A, S_ACK_R: begin
               if (scl_rise && st_q == S_ACK_R)
                  sh_q[0] <= sda_s;
               if (load_rd) begin
                  sh_q      <= rd_data;
                  o_sda_oe  <= ~rd_data[7];
                  ptr_q     <= ptr_q + 8'h1;
                  bit_cnt_q <= 4'h0;
                  st_q      <= S_RD;
               end else if (scl_fall) begin
                  o_sda_oe <= 1'b0;
                  st_q     <= (st_q == S_ACK_A) ? S_WR : S_IDLE;
               end
            end
            S_ACK_W: begin
               if (scl_fall) begin
                  o_sda_oe <= 1'b0;
                  st_q     <= S_WR;
               end
            end
            S_RD: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_q == 4'h8) begin
                     o_sda_oe <= 1'b0;
                     st_q     <= S_ACK_R;
                  end else begin
                     sh_q     <= {sh_q[6:0], 1'b0};
                     o_sda_oe <= ~sh_q[6];
                  end
               end
            end
            default: begin
               o_sda_oe <= 1'b0;
               st_q     <= S_IDLE;
            end
         endcase
      end
   end

   // pin outputs
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_sda_out              <= 1'b0;
         o_module_present_n_out <= 1'b0;
         o_module_present_n_oe  <= 1'b1;
         o_interrupt_n          <= 1'b1;
         o_tx_off               <= 4'hf;
         o_receive_loss_alarm   <= 1'b0;
         o_low_power_active     <= 1'b1;
      end else begin
         o_sda_out              <= 1'b0;
         o_module_present_n_out <= 1'b0;
         o_module_present_n_oe  <= 1'b1;
         o_interrupt_n          <= ~int_flag_q;
         o_tx_off               <= {4{txd_s}} | transmit_disable_q;
         o_receive_loss_alarm   <= |los_s;
         o_low_power_active     <= lpm_s;
      end
   end
endmodule // lsc_top

//--- src/lsc_defines.vh
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

// timing
`define LSC_CLK_PERIOD_NS   25
`define LSC_RST_MIN_NS      10000
`define LSC_INIT_NS         2000

// two-wire bus
`define LSC_DEV_ADDR        7'h50
`define LSC_ID_VALUE        8'h5a

// memory map byte offsets
`define LSC_A_ID            8'h00
`define LSC_A_STATUS        8'h01
`define LSC_A_LOS_FLAGS     8'h02
`define LSC_A_TRANSMIT_DISABLE        8'h03
`define LSC_A_RXPWR0        8'h04
`define LSC_A_RXPWR1        8'h05
`define LSC_A_RXPWR2        8'h06
`define LSC_A_RXPWR3        8'h07

// status bits
`define LSC_ST_DNR          0
`define LSC_ST_INT          1
`define LSC_ST_LPM          2
`define LSC_ST_TXPIN        3

// reset values
`define LSC_TRANSMIT_DISABLE_RST      4'h0
`define LSC_SYNC_RST        10'h00f

// synchroniser bit positions
`define LSC_S_SCL           0
`define LSC_S_SDA           1
`define LSC_S_SEL           2
`define LSC_S_RST           3
`define LSC_S_LPM           4
`define LSC_S_TXD           5
`define LSC_S_LOS           6

`endif

//--- src/lsc_sync.v
`timescale 1ns/1ps
// two flip-flop synchroniser, per-bit reset value
module lsc_sync #(
   parameter       W       = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input  wire         i_ref_clk,
   input  wire         i_rst_n,
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule // lsc_sync

//--- tb/lsc_checker.sv
`timescale 1ns/1ps
module lsc_checker #(
   parameter INIT_NS = 2000
) (
   input wire       i_ref_clk,
   input wire       i_rst_n,
   input wire       i_module_select_n,
   input wire       i_low_power_select,
   input wire       o_sda_out,
   input wire       o_sda_oe,
   input wire       o_module_present_n_out,
   input wire       o_module_present_n_oe,
   input wire       o_interrupt_n,
   input wire       i_transmit_disable,
   input wire [3:0] o_tx_off,
   input wire [3:0] i_lane_below_thr,
   input wire       o_receive_loss_alarm,
   input wire       o_low_power_active
);
   localparam int INIT_CYC = INIT_NS / 25;
   localparam int POST_CYC = INIT_CYC + 2;
   reg [15:0] cnt_q;
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) cnt_q <= 16'h0000;
      else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   a_present_held: assert property (o_module_present_n_oe && !o_module_present_n_out)
      else $error("presence line not pulled low");
   a_sda_open_drain: assert property (o_sda_out == 1'b0)
      else $error("data line driven high");
   a_tx_pin_off: assert property (i_transmit_disable [*5] |-> o_tx_off == 4'hf)
      else $error("transmitter on while pin asserted");
   a_loss_any_lane: assert property (|i_lane_below_thr [*5] |-> o_receive_loss_alarm)
      else $error("loss alarm missing");
   a_loss_no_lane: assert property ((i_lane_below_thr == 4'h0) [*5] |-> !o_receive_loss_alarm)
      else $error("loss alarm without low lane");
   a_lpm_follow: assert property ($stable(i_low_power_select) [*6]
      |-> o_low_power_active == i_low_power_select)
      else $error("low power output wrong");
   a_deselect_quiet: assert property (i_module_select_n [*6] |-> !o_sda_oe)
      else $error("bus answered while deselected");
   a_int_posted: assert property (cnt_q == POST_CYC |-> ##[0:4] !o_interrupt_n)
      else $error("completion interrupt not posted");
   a_bus_early: assert property (cnt_q < INIT_CYC |-> !o_sda_oe)
      else $error("bus answered before ready");
   c_ack: cover property (!o_sda_oe ##1 o_sda_oe);
   c_loss: cover property ($rose(o_receive_loss_alarm));
   c_int: cover property ($fell(o_interrupt_n));
endmodule // lsc_checker
bind lsc_top lsc_checker #(.INIT_NS(INIT_NS)) u_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_module_select_n(i_module_select_n),
   .i_low_power_select(i_low_power_select), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_module_present_n_out(o_module_present_n_out),
   .o_module_present_n_oe(o_module_present_n_oe), .o_interrupt_n(o_interrupt_n),
   .i_transmit_disable(i_transmit_disable), .o_tx_off(o_tx_off),
   .i_lane_below_thr(i_lane_below_thr), .o_receive_loss_alarm(o_receive_loss_alarm),
   .o_low_power_active(o_low_power_active));

//--- tb/lsc_host_model.sv
`timescale 1ns/1ps
module lsc_host_model (
   input  wire i_ref_clk,
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda_pull
);
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end
   task hc;
      repeat (2) @(negedge i_ref_clk);
   endtask
   task start;
      begin
         o_sda_pull = 1'b0;
         hc;
         o_scl = 1'b1;
         hc;
         o_sda_pull = 1'b1;
         hc;
         o_scl = 1'b0;
         hc;
      end
   endtask
   task stop;
      begin
         o_sda_pull = 1'b1;
         hc;
         o_scl = 1'b1;
         hc;
         o_sda_pull = 1'b0;
         hc;
      end
   endtask
   // msb first, clock left low after each byte
   task byte_io(input [7:0] d, input ack_in, output [7:0] q, output ack);
      integer i;
      begin
         for (i = 8; i >= 0; i = i - 1) begin
            o_sda_pull = (i == 0) ? ~ack_in : ~d[i-1];
            hc;
            o_scl = 1'b1;
            hc;
            if (i == 0) ack = i_sda;
            else q[i-1] = i_sda;
            hc;
            o_scl = 1'b0;
            hc;
         end
      end
   endtask
endmodule // lsc_host_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "lsc_defines.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
   $display("BAD %s exp %h got %h", n, e, a); end end
module tb_top;
   reg        clk = 1'b0;
   reg        rst_n = 1'b0;
   reg        sel_n = 1'b1;
   reg        mrst_n = 1'b1;
   reg        lps = 1'b0;
   reg        txd = 1'b0;
   reg  [3:0] lanes = 4'h0;
   wire       scl;
   wire       pull;
   wire       sda_oe;
   wire       sda_out;
   wire       pres_out;
   wire       pres_oe;
   wire       int_n;
   wire [3:0] tx_off;
   wire       loss;
   wire       lpa;
   wire       sda = ~(pull | sda_oe);
   int        failures = 0;
   int        num_checks = 0;
   reg  [7:0] q;
   reg        a0, a1, a2;
   initial forever #12.5 clk = ~clk;
   lsc_top #(.RST_MIN_NS(500), .INIT_NS(200)) u_dut (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_module_select_n(sel_n),
      .i_module_reset_n(mrst_n), .i_low_power_select(lps), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_module_present_n_out(pres_out),
      .o_module_present_n_oe(pres_oe), .o_interrupt_n(int_n), .i_transmit_disable(txd),
      .o_tx_off(tx_off), .i_lane_below_thr(lanes), .o_receive_loss_alarm(loss),
      .i_rx_power(32'h44332211), .o_low_power_active(lpa));
   lsc_host_model u_host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
   task end_sim;
      begin
         if (failures == 0 && num_checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task wait_int;
      integer n;
      begin
         for (n = 0; n < 400 && int_n !== 1'b0; n++) @(negedge clk);
         if (int_n !== 1'b0) begin
            failures++;
            end_sim;
         end
      end
   endtask
   task wr(input [7:0] p, input [7:0] d, input e);
      begin
         u_host.start;
         u_host.byte_io({`LSC_DEV_ADDR, 1'b0}, 1'b1, q, a0);
         u_host.byte_io(p, 1'b1, q, a1);
         u_host.byte_io(d, 1'b1, q, a2);
         u_host.stop;
         `CHK("wr ack", e, a0 | a1 | a2)
      end
   endtask
   task rd(input [7:0] p, input [7:0] e);
      begin
         u_host.start;
         u_host.byte_io({`LSC_DEV_ADDR, 1'b0}, 1'b1, q, a0);
         u_host.byte_io(p, 1'b1, q, a1);
         u_host.start;
         u_host.byte_io({`LSC_DEV_ADDR, 1'b1}, 1'b1, q, a2);
         u_host.byte_io(8'hff, 1'b1, q, a0);
         u_host.stop;
         `CHK("rd data", e, q)
      end
   endtask
   task t_powerup;
      begin
         wait_int;
         `CHK("present", 2'b10, {pres_oe, pres_out})
         `CHK("tx_off", 4'h0, tx_off)
         `CHK("loss", 1'b0, loss)
         sel_n = 1'b0;
         rd(`LSC_A_STATUS, 8'h02);
         repeat (4) @(negedge clk);
         `CHK("int_n", 1'b1, int_n)
         rd(`LSC_A_ID, `LSC_ID_VALUE);
         rd(`LSC_A_RXPWR2, 8'h33);
      end
   endtask
   task t_tx;
      begin
         wr(`LSC_A_TRANSMIT_DISABLE, 8'h05, 1'b0);
         repeat (4) @(negedge clk);
         `CHK("tx_off", 4'h5, tx_off)
         txd = 1'b1;
         repeat (6) @(negedge clk);
         `CHK("tx_off", 4'hf, tx_off)
         txd = 1'b0;
         repeat (6) @(negedge clk);
         rd(`LSC_A_TRANSMIT_DISABLE, 8'h05);
         sel_n = 1'b1;
         repeat (6) @(negedge clk);
         wr(`LSC_A_TRANSMIT_DISABLE, 8'h0a, 1'b1);
         `CHK("tx_off", 4'h5, tx_off)
         sel_n = 1'b0;
      end
   endtask
   task t_loss;
      begin
         lanes = 4'h4;
         repeat (6) @(negedge clk);
         `CHK("loss", 1'b1, loss)
         wait_int;
         rd(`LSC_A_LOS_FLAGS, 8'h04);
         lanes = 4'h0;
         repeat (6) @(negedge clk);
         `CHK("loss", 1'b0, loss)
         rd(`LSC_A_STATUS, 8'h02);
         lps = 1'b1;
         repeat (6) @(negedge clk);
         `CHK("lpa", 1'b1, lpa)
         rd(`LSC_A_STATUS, 8'h04);
         lps = 1'b0;
      end
   endtask
   task t_burst;
      reg [7:0] q0;
      begin
         u_host.start;
         u_host.byte_io({`LSC_DEV_ADDR, 1'b0}, 1'b1, q, a0);
         u_host.byte_io(`LSC_A_RXPWR0, 1'b1, q, a1);
         u_host.start;
         u_host.byte_io({`LSC_DEV_ADDR, 1'b1}, 1'b1, q, a2);
         u_host.byte_io(8'hff, 1'b0, q0, a0);
         u_host.byte_io(8'hff, 1'b1, q, a1);
         u_host.stop;
         `CHK("burst", 16'h1122, {q0, q})
      end
   endtask
   task t_mreset;
      begin
         mrst_n = 1'b0;
         repeat (25) @(negedge clk);
         mrst_n = 1'b1;
         wr(`LSC_A_TRANSMIT_DISABLE, 8'h0f, 1'b1);
         wait_int;
         rd(`LSC_A_TRANSMIT_DISABLE, 8'h00);
         rd(`LSC_A_STATUS, 8'h02);
      end
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      t_powerup;
      t_tx;
      t_loss;
      t_burst;
      t_mreset;
      end_sim;
   end
endmodule // tb_top
